// >>> verilog/tawg_consts.svh
`ifndef TAWG_CONSTS_SVH
`define TAWG_CONSTS_SVH
// Operation
// - A write to a protected bit takes effect only while the window is open, else it is dropped.
// - Writing AAh to the key register starts a count that waits 3 machine cycles for 55h.
// - The window opens only when 55h follows AAh within 3 machine cycles.
// - An open window stays open 3 machine cycles and then closes by itself.
// - The key register is decoded at special-function address C7h, both key bytes go there.
// - Watchdog control, memory size adjust, wait-state and power-reset flag are protected.
// - A 55h arriving 4 machine cycles after AAh opens nothing, later protected writes fail.

// Register addresses
`define TAWG_ADDR_KEY       8'hC7
`define TAWG_ADDR_WDCTL     8'hD8
`define TAWG_ADDR_SYSCTL    8'h8E
`define TAWG_ADDR_STATUS    8'hC6
// Key bytes
`define TAWG_KEY_FIRST      8'hAA
`define TAWG_KEY_SECOND     8'h55
// Machine cycle timing
`define TAWG_CLKS_PER_MC    4
`define TAWG_ARM_MC         3
`define TAWG_OPEN_MC        3
// Reset values
`define TAWG_WDCTL_RST      8'h00
`define TAWG_SYSCTL_RST     8'h00
// Field positions
`define TAWG_WD_RESTART_BIT 0
`define TAWG_WD_RSTEN_BIT   1
`define TAWG_WD_RSTFLAG_BIT 2
`define TAWG_WD_POR_BIT     6
`endif

// >>> verilog/tawg_pkg.sv
package tawg_pkg;
  typedef enum logic [1:0] {
    TAWG_IDLE  = 2'b00,
    TAWG_ARMED = 2'b01,
    TAWG_OPEN  = 2'b10
  } tawg_state_type;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } tawg_bus_type;
endpackage

// >>> verilog/tawg_mc_tick.sv
`timescale 1ns/100ps
`include "tawg_consts.svh"
// Machine cycle tick generator
module tawg_mc_tick #(
  parameter int CLKS_PER_MC = `TAWG_CLKS_PER_MC
) (
  input  wire logic ref_clk_i,
  input  wire logic sys_rst_i,
  output logic      tick_o
);
  logic [3:0] div_cnt;

  // Divide core clock into machine cycles
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      div_cnt <= 4'h0;
    end else if (div_cnt == 4'(CLKS_PER_MC - 1)) begin
      div_cnt <= 4'h0;
    end else begin
      div_cnt <= div_cnt + 4'h1;
    end
  end

  assign tick_o = (div_cnt == 4'(CLKS_PER_MC - 1));
endmodule

// >>> verilog/tawg_guard.sv
// The address-and-strobe port was decided locally.
`timescale 1ns/100ps
`include "tawg_consts.svh"
////////////////////////////////////////////////////////////////////////////////
// Timed access write guard
module tawg_guard #(
  parameter int CLKS_PER_MC = `TAWG_CLKS_PER_MC,
  parameter int ARM_MC      = `TAWG_ARM_MC,
  parameter int OPEN_MC     = `TAWG_OPEN_MC
) (
  input  wire logic       ref_clk_i,
  input  wire logic       sys_rst_i,
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  input  wire logic       wd_flag_set_i,
  input  wire logic       por_flag_set_i,
  output logic [7:0]      rdata_o,
  output logic            window_open_o,
  output logic            wd_restart_o,
  output logic            wd_reset_en_o,
  output logic [1:0]      wd_interval_o,
  output logic [2:0]      rom_size_o,
  output logic [1:0]      wait_states_o,
  output logic            blocked_o
);
  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  tawg_pkg::tawg_bus_type   bus;
  tawg_pkg::tawg_state_type state;
  logic [3:0]               mc_cnt;
  logic                     mc_tick;
  logic [7:0]               wdctl;
  logic [7:0]               sysctl;
  logic                     wr_key;
  logic                     wr_wdctl;
  logic                     wr_sysctl;
  logic                     drop_seen;

  assign bus = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

  // Address match on a write
  function automatic logic hit(input tawg_pkg::tawg_bus_type b, input logic [7:0] a);
    hit = b.wr && (b.addr == a);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Machine cycle timing
  tawg_mc_tick #(
    .CLKS_PER_MC(CLKS_PER_MC)
  ) u_tick (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .tick_o   (mc_tick)
  );

  assign wr_key    = hit(bus, `TAWG_ADDR_KEY);
  assign wr_wdctl  = hit(bus, `TAWG_ADDR_WDCTL);
  assign wr_sysctl = hit(bus, `TAWG_ADDR_SYSCTL);

  ////////////////////////////////////////////////////////////////////////////
  // Unlock sequencer
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      state  <= tawg_pkg::TAWG_IDLE;
      mc_cnt <= 4'h0;
    end else begin
      unique case (state)
        tawg_pkg::TAWG_IDLE: begin
          if (wr_key && wdata_i == `TAWG_KEY_FIRST) begin
            state  <= tawg_pkg::TAWG_ARMED;
            mc_cnt <= 4'h0;
          end
        end
        tawg_pkg::TAWG_ARMED: begin
          if (wr_key && wdata_i == `TAWG_KEY_SECOND) begin
            state  <= tawg_pkg::TAWG_OPEN;
            mc_cnt <= 4'h0;
          end else if (wr_key && wdata_i == `TAWG_KEY_FIRST) begin
            mc_cnt <= 4'h0; // Fresh first key restarts
          end else if (wr_key) begin
            state <= tawg_pkg::TAWG_IDLE;
          end else if (mc_tick) begin
            if (mc_cnt == 4'(ARM_MC - 1)) begin
              state <= tawg_pkg::TAWG_IDLE;
            end else begin
              mc_cnt <= mc_cnt + 4'h1;
            end
          end
        end
        tawg_pkg::TAWG_OPEN: begin
          if (mc_tick) begin
            if (mc_cnt == 4'(OPEN_MC - 1)) begin
              state <= tawg_pkg::TAWG_IDLE;
            end else begin
              mc_cnt <= mc_cnt + 4'h1;
            end
          end
        end
        default: begin
          state <= tawg_pkg::TAWG_IDLE;
        end
      endcase
    end
  end

  assign window_open_o = (state == tawg_pkg::TAWG_OPEN);

  ////////////////////////////////////////////////////////////////////////////
  // Protected watchdog control
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      wdctl <= `TAWG_WDCTL_RST;
    end else begin
      if (wr_wdctl && window_open_o) begin
        wdctl <= wdata_i;
      end else begin
        wdctl[`TAWG_WD_RESTART_BIT] <= 1'b0; // Restart self clears
      end
      // Hardware sets win over software clear
      if (wd_flag_set_i) begin
        wdctl[`TAWG_WD_RSTFLAG_BIT] <= 1'b1;
      end
      if (por_flag_set_i) begin
        wdctl[`TAWG_WD_POR_BIT] <= 1'b1;
      end
    end
  end

  // Protected system control: size and wait states
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      sysctl <= `TAWG_SYSCTL_RST;
    end else if (wr_sysctl && window_open_o) begin
      sysctl <= wdata_i;
    end
  end

  // Sticky indicator of dropped protected writes
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      drop_seen <= 1'b0;
    end else if ((wr_wdctl || wr_sysctl) && !window_open_o) begin
      drop_seen <= 1'b1;
    end else if (rd_i && addr_i == `TAWG_ADDR_STATUS) begin
      drop_seen <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data, one cycle after strobe
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      unique case (addr_i)
        `TAWG_ADDR_WDCTL:  rdata_o <= wdctl;
        `TAWG_ADDR_SYSCTL: rdata_o <= sysctl;
        `TAWG_ADDR_STATUS: rdata_o <= {5'h00, drop_seen, state};
        default:           rdata_o <= 8'h00;
      endcase
    end else begin
      rdata_o <= 8'h00;
    end
  end

  // Control outputs
  assign wd_restart_o  = wdctl[`TAWG_WD_RESTART_BIT];
  assign wd_reset_en_o = wdctl[`TAWG_WD_RSTEN_BIT];
  assign wd_interval_o = wdctl[5:4];
  assign rom_size_o    = sysctl[2:0];
  assign wait_states_o = sysctl[5:4];
  assign blocked_o     = drop_seen;
endmodule

// >>> bench/tawg_guard_checker.sv
`timescale 1ns/100ps
////////////////////////////////////////
// Key sequence and window watcher
module tawg_guard_checker (
  input wire logic       ref_clk_i,
  input wire logic       sys_rst_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic       wr_i,
  input wire logic       rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic       window_open_o,
  input wire logic       wd_restart_o,
  input wire logic       wd_reset_en_o,
  input wire logic [1:0] wd_interval_o,
  input wire logic [2:0] rom_size_o,
  input wire logic [1:0] wait_states_o,
  input wire logic       blocked_o
);
  logic k_c7;
  logic k_aa;
  logic k_55;
  logic prot;
  // Decoded key and protected writes
  assign k_c7 = wr_i && addr_i == 8'hC7;
  assign k_aa = k_c7 && wdata_i == 8'hAA;
  assign k_55 = k_c7 && wdata_i == 8'h55;
  assign prot = wr_i && (addr_i == 8'hD8 || addr_i == 8'h8E);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  a_key_opens: assert property (k_aa ##1 k_55 |=> window_open_o)
    else $error("window not opened by key");
  a_open_cause: assert property ($rose(window_open_o) |-> $past(k_55))
    else $error("window opened without key");
  a_window_ends: assert property ($rose(window_open_o) |->
    window_open_o[*8] ##[1:5] !window_open_o) else $error("window length wrong");
  a_drop_flag: assert property (prot && !window_open_o |=> blocked_o)
    else $error("drop not flagged");
  a_drop_holds: assert property (prot && !window_open_o |=>
    $stable({wd_reset_en_o, wd_interval_o, rom_size_o, wait_states_o}))
    else $error("closed write changed a bit");
  a_wd_takes: assert property (wr_i && addr_i == 8'hD8 && window_open_o |=>
    {wd_interval_o, wd_reset_en_o} == {$past(wdata_i[5:4]), $past(wdata_i[1])})
    else $error("watchdog write lost");
  a_sys_takes: assert property (wr_i && addr_i == 8'h8E && window_open_o |=>
    {rom_size_o, wait_states_o} == {$past(wdata_i[2:0]), $past(wdata_i[5:4])})
    else $error("system write lost");
  a_late_key: assert property (k_aa ##1 (!wr_i)[*8] ##1 (!wr_i)[*7] ##1 k_55
    |=> !window_open_o) else $error("late key opened");
  a_wrong_key: assert property (k_aa ##1 (k_c7 && !k_55) ##1 k_55
    |=> !window_open_o) else $error("cancel ignored");
  a_key_reads: assert property (rd_i && addr_i == 8'hC7 |=> rdata_o == 8'h00)
    else $error("key readable");
  a_restart_clears: assert property (wd_restart_o && !(prot && window_open_o) |=>
    !wd_restart_o) else $error("restart bit stuck");
endmodule

// >>> bench/tawg_guard_test.sv
`timescale 1ns/100ps
////////////////////////////////////////
// Drives key sequences and protected writes
module tawg_guard_test;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [7:0]  ad = 8'h00;
  logic [7:0]  wd = 8'h00;
  logic [7:0]  rdat;
  logic        win;
  logic        blk;
  logic        wrs;
  logic [1:0]  hs = 2'h0;
  logic        wen;
  logic [1:0]  wint;
  logic [1:0]  ws;
  logic [2:0]  rom;
  logic [24:0] rows [6];
  int          err_total = 0;
  int          n_checks = 0;
  int          k;
  wire  [7:0]  outs = {wint, wen, rom, ws};
  tawg_guard i_tawg_guard (.ref_clk_i(clk), .sys_rst_i(rst), .addr_i(ad), .wdata_i(wd),
    .wr_i(wr), .rd_i(rd), .wd_flag_set_i(hs[0]), .por_flag_set_i(hs[1]), .rdata_o(rdat),
    .window_open_o(win), .wd_restart_o(wrs), .wd_reset_en_o(wen), .wd_interval_o(wint),
    .rom_size_o(rom), .wait_states_o(ws), .blocked_o(blk));
  // Clock at 40 MHz
  always #12.5 clk = ~clk;
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("mismatch at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic cyc(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= w;
    rd <= r;
    ad <= a;
    wd <= d;
  endtask
  task automatic key(input logic [7:0] d);
    cyc(1'h1, 1'h0, 8'hC7, d);
  endtask
  task automatic idle(input int n);
    repeat (n) cyc(1'h0, 1'h0, 8'h00, 8'h00);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    cyc(1'h0, 1'h1, a, 8'h00);
    idle(1);
    #1 chk(rdat, e);
  endtask
  task automatic close_out;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    rows = '{{1'h1, 8'hD8, 8'h32, 8'hE0}, {1'h1, 8'h8E, 8'h25, 8'hF6},
      {1'h0, 8'hD8, 8'h00, 8'hF6}, {1'h0, 8'h8E, 8'h00, 8'hF6},
      {1'h1, 8'hD8, 8'h10, 8'h56}, {1'h1, 8'h8E, 8'h00, 8'h40}};
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    idle(1);
    #1 chk({win, blk, outs[7:2]}, 8'h00);
    for (k = 0; k < 6; k++) begin
      if (rows[k][24]) begin
        key(8'hAA);
        key(8'h55);
      end
      cyc(1'h1, 1'h0, rows[k][23:16], rows[k][15:8]);
      idle(1);
      #1 chk(outs, rows[k][7:0]);
      idle(14);
    end
    chk({7'h00, blk}, 8'h01);
    rdc(8'hC6, 8'h04);
    rdc(8'hC6, 8'h00);
    rdc(8'hC7, 8'h00);
    rdc(8'h00, 8'h00);
    rdc(8'hD8, 8'h10);
    rdc(8'h8E, 8'h00);
    // Restart bit pulses for one cycle
    key(8'hAA);
    key(8'h55);
    cyc(1'h1, 1'h0, 8'hD8, 8'h11);
    idle(1);
    #1 chk({7'h00, wrs}, 8'h01);
    idle(1);
    #1 chk({7'h00, wrs}, 8'h00);
    idle(14);
    key(8'hAA);
    idle(15);
    key(8'h55);
    cyc(1'h1, 1'h0, 8'hD8, 8'hFF);
    idle(1);
    #1 chk(outs, 8'h40);
    key(8'hAA);
    key(8'h12);
    key(8'h55);
    idle(1);
    #1 chk({7'h00, win}, 8'h00);
    key(8'hAA);
    key(8'h55);
    k = 0;
    do begin
      idle(1);
      #1 k++;
    end while (win === 1'b1 && k < 20);
    chk({7'h00, k >= 9 && k <= 13}, 8'h01);
    cyc(1'h1, 1'h0, 8'h8E, 8'h3F);
    idle(1);
    #1 chk(outs, 8'h40);
    // Hardware flag sets land in watchdog control
    @(posedge clk);
    hs <= 2'h3;
    @(posedge clk);
    hs <= 2'h0;
    rdc(8'hD8, 8'h54);
    // Mid-run reset clears everything
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    idle(1);
    #1 chk({win, blk, outs[7:2]}, 8'h00);
    chk(outs, 8'h00);
    close_out();
  end
endmodule
bind tawg_guard tawg_guard_checker i_tawg_guard_checker (.ref_clk_i, .sys_rst_i, .addr_i,
  .wdata_i, .wr_i, .rd_i, .rdata_o, .window_open_o, .wd_restart_o, .wd_reset_en_o,
  .wd_interval_o,
  .rom_size_o, .wait_states_o, .blocked_o);
